// ### design/sleep_controller.sv
// radio module sleep controller: decides when to sleep, wake and poll
// assumes host pins are synchronous to CLK_I and radio events are one-cycle pulses
// Functional notes
// - decode mode 0,1,4,5,6
// - modes 1,5 sleep only with request asserted; mode 5 still sleeps after drain if the request drops while draining
// - modes 4,5 sleep after idle hold time
// - pin sleep finishes traffic, idles, sleeps
// - asleep in pin mode ignores all activity
// - wake on release; cts low when ready
// - host waits two byte times after cts
// - host sets sleep pin function to 1
// - select pin substitutes when configured so
// - host disables other spi pins
// - cyclic wake polls once per period
// - coordinator returns queued data on poll
// - no data nor serial: sleep at once
// - activity on cyclic wake holds awake
// - option bit 8 forces full hold
// - cyclic wake raises awake, lowers cts
// - mode 5 low pin wakes, hold minimum
// - awake indicator low asleep, high awake
//
// Chosen here: the register addresses and the address-and-strobe port.
module sleep_controller
  import sleep_ctrl_pkg::*;
#(
  parameter int unsigned TICK_LEN  = TICK_CYCLES,
  parameter int unsigned READY_LEN = READY_CYCLES
) (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  sleep_link_if.device LINK,
  input  wire logic RF_BUSY_I,       // radio transmit or receive in progress
  input  wire logic RF_ACTIVITY_I,   // pulse: radio frame received or sent
  input  wire logic POLL_DONE_I,     // pulse: poll answered, no queued data
  output logic      POLL_REQ_O,      // pulse: send poll to coordinator
  output logic      ASLEEP_O         // radio power-down request
);

  // whole module state in one struct
  typedef struct packed {
    dev_state_t  state;
    logic [31:0] tick_cnt;   // divider toward the slow tick
    logic        tick;       // one-cycle slow tick
    logic [15:0] period_cnt; // time to next cyclic wake
    logic [15:0] hold_cnt;   // wake hold down-counter
    logic [15:0] ready_cnt;  // wake-to-ready delay
    logic        pin_wake;   // woken by pin in mode 5
    logic        cyclic;     // current wake is a cyclic one
    logic        polled;     // poll answered in this wake
    logic        awake;
    logic        cts_n;
    logic        poll_req;
    logic        asleep;
  } st_t;

  st_t s_reg;   // registered state
  st_t s_next;  // next state

  logic req;         // effective sleep request level
  logic pin_mode;    // modes using the request pin
  logic cyc_mode;    // cyclic modes
  logic activity;    // serial or radio event
  logic hold_zero;   // hold counter expired

  // request source selection and mode decode
  always_comb begin
    if (LINK.sleep_pin_function) begin
      req = LINK.sleep_req;
    end else if (LINK.select_pin_function) begin
      req = LINK.spi_select;
    end else begin
      req = 1'b0;
    end
    pin_mode  = (LINK.mode == MODE_PIN) || (LINK.mode == MODE_CYCLIC_PIN);
    cyc_mode  = (LINK.mode == MODE_CYCLIC) || (LINK.mode == MODE_CYCLIC_PIN);
    activity  = LINK.ser_activity || RF_ACTIVITY_I;
    hold_zero = (s_reg.hold_cnt == 16'h0000);
  end

  // next-state logic
  always_comb begin
    s_next          = s_reg;
    s_next.poll_req = 1'b0;
    // slow tick divider, one clock only
    if (s_reg.tick_cnt >= TICK_LEN - 1) begin
      s_next.tick_cnt = 32'h0000_0000;
      s_next.tick     = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 32'h0000_0001;
      s_next.tick     = 1'b0;
    end
    // hold counter reload and count down
    if (activity && s_reg.state != ST_ASLEEP) begin
      s_next.hold_cnt = LINK.hold;
    end else if (s_reg.tick && !hold_zero) begin
      s_next.hold_cnt = s_reg.hold_cnt - 16'h0001;
    end
    // cyclic period counter runs only while asleep
    if (s_reg.state == ST_ASLEEP && cyc_mode && s_reg.tick && s_reg.period_cnt != 16'h0000) begin
      s_next.period_cnt = s_reg.period_cnt - 16'h0001;
    end
    if (POLL_DONE_I && s_reg.cyclic) begin
      s_next.polled = 1'b1;
    end
    unique case (s_reg.state)
      ST_ASLEEP: begin
        s_next.awake  = 1'b0;
        s_next.cts_n  = 1'b1;
        s_next.asleep = 1'b1;
        // pin sleep ignores serial and radio
        if (LINK.mode == MODE_NONE || LINK.mode == MODE_SCRIPT) begin
          s_next.state = ST_WAKING;
        end else if (LINK.mode == MODE_PIN && !req) begin
          s_next.state = ST_WAKING;
        end else if (LINK.mode == MODE_CYCLIC_PIN && !req) begin
          s_next.state    = ST_WAKING;
          s_next.pin_wake = 1'b1;
          s_next.hold_cnt = LINK.hold;
        end else if (cyc_mode && s_reg.period_cnt == 16'h0000) begin
          s_next.state    = ST_WAKING;
          s_next.cyclic   = 1'b1;
          s_next.polled   = 1'b0;
          s_next.hold_cnt = LINK.full_hold ? LINK.hold : 16'h0000;
        end
        s_next.ready_cnt = 16'h0000;
      end
      ST_WAKING: begin
        s_next.asleep = 1'b0;
        s_next.awake  = 1'b1;
        if (s_reg.ready_cnt >= 16'(READY_LEN - 1)) begin
          s_next.cts_n = 1'b0;
          s_next.state = ST_AWAKE;
          if (s_reg.cyclic) begin
            s_next.poll_req   = 1'b1;
            s_next.period_cnt = LINK.period;
          end
        end else begin
          s_next.ready_cnt = s_reg.ready_cnt + 16'h0001;
        end
      end
      ST_AWAKE: begin
        s_next.awake = 1'b1;
        s_next.cts_n = 1'b0;
        if (LINK.mode == MODE_PIN && req) begin
          s_next.state = ST_DRAIN;
        end else if (cyc_mode) begin
          if (LINK.mode == MODE_CYCLIC_PIN && !req) begin
            // pin still low keeps device awake
            s_next.hold_cnt = (hold_zero) ? 16'h0001 : s_reg.hold_cnt;
          end else if (hold_zero && !activity && !RF_BUSY_I) begin
            if (!s_reg.cyclic || s_reg.polled || s_reg.pin_wake) begin
              s_next.state = ST_DRAIN;
            end
          end
        end
      end
      ST_DRAIN: begin
        s_next.cts_n = 1'b1;
        if (!RF_BUSY_I) begin
          if (LINK.mode == MODE_PIN && !req) begin
            s_next.state = ST_AWAKE;
            s_next.cts_n = 1'b0;
          end else begin
            s_next.state      = ST_ASLEEP;
            s_next.awake      = 1'b0;
            s_next.asleep     = 1'b1;
            s_next.pin_wake   = 1'b0;
            s_next.cyclic     = 1'b0;
            // restart the period on every sleep
            // a leftover count from an earlier mode would stretch the interval
            s_next.period_cnt = LINK.period;
          end
        end
      end
      default: s_next.state = ST_ASLEEP;
    endcase
    // mode 0 never sleeps
    if (LINK.mode == MODE_NONE && s_next.state == ST_DRAIN) begin
      s_next.state = ST_AWAKE;
    end
  end

  // state register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_reg            <= '0;
      s_reg.state      <= ST_WAKING;
      s_reg.cts_n      <= 1'b1;
      s_reg.period_cnt <= PERIOD_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign LINK.awake = s_reg.awake;
  assign LINK.cts_n = s_reg.cts_n;
  assign POLL_REQ_O = s_reg.poll_req;
  assign ASLEEP_O   = s_reg.asleep;

endmodule : sleep_controller

// ### design/sleep_ctrl_pkg.sv
// shared constants and types for the radio module sleep controller and its host end
// assumes one 125 MHz clock shared by both ends
package sleep_ctrl_pkg;
  localparam int unsigned CLK_HZ             = 125_000_000;
  // base tick for the period and hold counters, in microseconds
  localparam int unsigned TICK_US            = 1000;
  localparam int unsigned TICK_CYCLES        = (CLK_HZ / 1_000_000) * TICK_US;
  // one serial byte time at a nominal 9600 baud, in nanoseconds
  localparam int unsigned BYTE_TIME_NS       = 1_041_667;
  localparam int unsigned BYTE_TIME_CYCLES   = (BYTE_TIME_NS + 7) / 8;
  // time from wake to ready, in nanoseconds
  localparam int unsigned READY_NS           = 1000;
  localparam int unsigned READY_CYCLES       = (READY_NS + 7) / 8;
  // sleep mode encodings
  localparam logic [2:0]  MODE_NONE          = 3'h0;
  localparam logic [2:0]  MODE_PIN           = 3'h1;
  localparam logic [2:0]  MODE_CYCLIC        = 3'h4;
  localparam logic [2:0]  MODE_CYCLIC_PIN    = 3'h5;
  localparam logic [2:0]  MODE_SCRIPT        = 3'h6;
  // option bit that forces a full hold on each cyclic wake
  localparam int unsigned OPT_FULL_HOLD_BIT  = 8;
  // host register offsets (host end command port)
  localparam logic [3:0]  HREG_CTRL          = 4'h0;
  localparam logic [3:0]  HREG_STATUS        = 4'h4;
  localparam logic [3:0]  HREG_CFG           = 4'h8;
  // reset values
  localparam logic [15:0] PERIOD_RST         = 16'h0064;
  localparam logic [15:0] HOLD_RST           = 16'h0032;
  localparam logic [2:0]  MODE_RST           = 3'h0;

  // device state, gray along sleep -> wake -> ready -> busy
  typedef enum logic [2:0] {
    ST_ASLEEP  = 3'b000,
    ST_WAKING  = 3'b001,
    ST_AWAKE   = 3'b011,
    ST_DRAIN   = 3'b010
  } dev_state_t;
endpackage : sleep_ctrl_pkg

// ### design/sleep_host.sv
// host end: drives sleep request and settings, watches awake and cts
// assumes a plain register port from software on the same clock
module sleep_host
  import sleep_ctrl_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  sleep_link_if.host       LINK,
  input  wire logic [3:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [31:0]      RDATA_O,
  output logic             SEND_OK_O   // serial may be sent now
);
  typedef struct packed {
    logic        sleep_req;
    logic        use_select;
    logic [2:0]  mode;
    logic        full_hold;
    logic [15:0] period;
    logic [15:0] hold;
    logic [31:0] gap_cnt;   // byte time counter after cts falls
    logic        send_ok;
    logic        ser_pulse;
    logic [31:0] rdata;
  } h_t;
  h_t h_reg;  // registered state
  h_t h_next; // next state

  // register writes, cts wait, reads
  always_comb begin
    h_next           = h_reg;
    h_next.ser_pulse = 1'b0;
    h_next.rdata     = 32'h0000_0000;
    if (WR_I) begin
      unique case (ADDR_I)
        HREG_CTRL: begin
          h_next.sleep_req  = WDATA_I[0];
          h_next.use_select = WDATA_I[1];
          h_next.ser_pulse  = WDATA_I[2] && h_reg.send_ok;
        end
        HREG_CFG: begin
          h_next.mode      = WDATA_I[2:0];
          h_next.full_hold = WDATA_I[OPT_FULL_HOLD_BIT];
          h_next.hold      = WDATA_I[31:16];
        end
        HREG_STATUS: h_next.period = WDATA_I[15:0];
        default: ;
      endcase
    end
    if (LINK.cts_n) begin
      h_next.gap_cnt = 32'h0000_0000;
      h_next.send_ok = 1'b0;
    end else if (h_reg.gap_cnt >= 32'(2 * BYTE_TIME_CYCLES)) begin
      h_next.send_ok = 1'b1;
    end else begin
      h_next.gap_cnt = h_reg.gap_cnt + 32'h0000_0001;
    end
    if (RD_I) begin
      h_next.rdata = {28'h0000000, h_reg.send_ok, LINK.cts_n, LINK.awake, h_reg.sleep_req};
    end
  end

  // state register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      h_reg        <= '0;
      h_reg.mode   <= MODE_RST;
      h_reg.period <= PERIOD_RST;
      h_reg.hold   <= HOLD_RST;
    end else begin
      h_reg <= h_next;
    end
  end

  // request pin function set to 1 unless the select pin is chosen as the request
  assign LINK.sleep_pin_function  = !h_reg.use_select;
  assign LINK.select_pin_function = h_reg.use_select;
  assign LINK.sleep_req    = h_reg.sleep_req;
  assign LINK.spi_select   = h_reg.sleep_req;
  assign LINK.ser_activity = h_reg.ser_pulse;
  assign LINK.mode         = h_reg.mode;
  assign LINK.period       = h_reg.period;
  assign LINK.hold         = h_reg.hold;
  assign LINK.full_hold    = h_reg.full_hold;
  assign RDATA_O           = h_reg.rdata;
  assign SEND_OK_O         = h_reg.send_ok;
endmodule : sleep_host

// ### design/sleep_link_if.sv
// interface joining the host end and the radio sleep controller
// assumes both ends run on the same clock; no tristate lines needed
interface sleep_link_if;
  logic       sleep_req;      // host sleep request pin, high asks for sleep
  logic       spi_select;     // alternative select pin used as sleep request
  logic       awake;          // awake indicator, high while awake
  logic       cts_n;          // clear to send, low when ready
  logic       ser_activity;   // one-cycle pulse: host serial byte sent
  logic [2:0] mode;           // sleep_mode_select setting
  logic [15:0] period;        // cyclic_sleep_period in ticks
  logic [15:0] hold;          // wake_hold_time in ticks
  logic       full_hold;      // sleep option bit 8
  logic       sleep_pin_function;
  logic       select_pin_function;
  modport device (input sleep_req, spi_select, ser_activity, mode, period, hold,
                  full_hold, sleep_pin_function, select_pin_function,
                  output awake, cts_n);
  modport host (output sleep_req, spi_select, ser_activity, mode, period, hold,
                full_hold, sleep_pin_function, select_pin_function,
                input awake, cts_n);
endinterface : sleep_link_if

// ### dv/sleep_link_properties.sv
// concurrent checks on the link between the host end and the sleep controller
// assumes one clock, async active-high reset, and the same tick length as the device
module sleep_link_properties
  import sleep_ctrl_pkg::*;
#(
  parameter int unsigned TICK_LEN = 4
) (
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        sleep_req,
  input wire logic        spi_select,
  input wire logic        awake,
  input wire logic        cts_n,
  input wire logic        ser_activity,
  input wire logic [2:0]  mode,
  input wire logic [15:0] period,
  input wire logic [15:0] hold,
  input wire logic        full_hold,
  input wire logic        sleep_pin_function,
  input wire logic        select_pin_function
);
  logic        req_eff;    // request level the device should follow
  logic [17:0] since_cts;  // cycles since cts fell, saturating
  logic [17:0] since_pin;  // cycles since the request pin was last low
  logic [17:0] since_slp;  // cycles spent asleep
  logic [17:0] since_wak;  // cycles spent awake
  assign req_eff = sleep_pin_function ? sleep_req : (select_pin_function & spi_select);
  // saturating counters; 18 bits cover two byte times, so no wrap can fake a pass
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      since_cts <= '0;
      since_pin <= '1;
      since_slp <= '0;
      since_wak <= '0;
    end else begin
      since_cts <= cts_n ? '0 : since_cts + 18'(since_cts != '1);
      since_pin <= !req_eff ? '0 : since_pin + 18'(since_pin != '1);
      since_slp <= awake ? '0 : since_slp + 18'(since_slp != '1);
      since_wak <= !awake ? '0 : since_wak + 18'(since_wak != '1);
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  AST_CTS_WHILE_ASLEEP: assert property (!awake |-> cts_n)
    else $error("cts low while asleep");
  AST_NEVER_SLEEP: assert property ((mode == MODE_NONE || mode == MODE_SCRIPT) && awake |=> awake)
    else $error("slept in a no-sleep mode");
  AST_SLEEP_NEEDS_REQ: assert property ($fell(awake) && ($past(mode) == MODE_PIN ||
    $past(mode) == MODE_CYCLIC_PIN) |-> $past(req_eff))
    else $error("pin mode slept without request");
  AST_PIN_WAKE: assert property (mode == MODE_PIN && !req_eff && !awake |-> ##[1:4] awake)
    else $error("no wake on request release");
  AST_CTS_AFTER_WAKE: assert property ($rose(awake) |-> cts_n ##[1:6] !cts_n)
    else $error("cts not lowered after wake");
  AST_PIN_STAY: assert property ((mode == MODE_PIN || mode == MODE_CYCLIC_PIN) && !req_eff &&
    awake |=> awake)
    else $error("slept while request low");
  AST_HOST_WAITS: assert property (ser_activity |-> !cts_n && since_cts >= 2 * BYTE_TIME_CYCLES - 2)
    else $error("host sent too soon after cts");
  AST_CYCLE_PERIOD: assert property ($rose(awake) && mode == MODE_CYCLIC |->
    since_slp + TICK_LEN >= period * TICK_LEN && since_slp <= period * TICK_LEN + TICK_LEN + 4)
    else $error("cyclic wake off period");
  AST_PIN_MIN_HOLD: assert property ($fell(awake) && $past(mode) == MODE_CYCLIC_PIN |->
    since_pin + TICK_LEN >= hold * TICK_LEN)
    else $error("pin wake shorter than hold");
  AST_FULL_HOLD: assert property ($fell(awake) && $past(mode) == MODE_CYCLIC && $past(full_hold) |->
    since_wak + TICK_LEN >= hold * TICK_LEN)
    else $error("full hold cut short");
endmodule // sleep_link_properties

// ### dv/tb_radio_module_sleep_controller.sv
// self-checking bench: host end and sleep controller joined by one link
// assumes 125 MHz clock; software port and radio pulses driven on rising edges
module tb_radio_module_sleep_controller;
  import sleep_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;  // short tick keeps hold and period runs brief
  logic        clk, rst, wr_s, rd_s, busy, act, done;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, ra, rb;
  logic        send_ok, poll_req, asleep;
  int          num_errors, cmp_count;
  sleep_link_if lnk();
  sleep_host sleep_host_i (.CLK_I(clk), .RST_I(rst), .LINK(lnk), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .SEND_OK_O(send_ok));
  sleep_controller #(.TICK_LEN(TICK), .READY_LEN(2)) sleep_controller_i (.CLK_I(clk), .RST_I(rst),
    .LINK(lnk), .RF_BUSY_I(busy), .RF_ACTIVITY_I(act), .POLL_DONE_I(done),
    .POLL_REQ_O(poll_req), .ASLEEP_O(asleep));
  sleep_link_properties #(.TICK_LEN(TICK)) sleep_link_properties_i (.CLK_I(clk), .RST_I(rst),
    .sleep_req(lnk.sleep_req), .spi_select(lnk.spi_select), .awake(lnk.awake),
    .cts_n(lnk.cts_n), .ser_activity(lnk.ser_activity), .mode(lnk.mode), .period(lnk.period),
    .hold(lnk.hold), .full_hold(lnk.full_hold), .sleep_pin_function(lnk.sleep_pin_function),
    .select_pin_function(lnk.select_pin_function));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic summarize();
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one write, then a spare edge so strobes never toggle twice in a step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    addr <= a; rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  // one-cycle radio pulse: poll answered empty when sel_done, else radio activity
  task automatic pulse(input bit sel_done);
    if (sel_done) begin
      done <= 1'b1;
    end else begin
      act <= 1'b1;
    end
    @(posedge clk);
    done <= 1'b0;
    act  <= 1'b0;
  endtask
  // bounded wait for the awake indicator, then judged
  task automatic wait_aw(input logic v, input int lim);
    int n;
    n = 0;
    while (lnk.awake !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(lnk.awake, v);
  endtask
  task automatic stay_aw(input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge clk);
      bad += int'(lnk.awake !== 1'b1);
    end
    chk(bad, 0);
  endtask
  task automatic wait_poll();
    int n;
    n = 0;
    while (poll_req !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(poll_req, 1'b1);
    chk(lnk.awake, 1'b1);
  endtask
  task automatic t_boot();
    wait_aw(1'b1, 10);
    repeat (8) @(posedge clk);
    chk(lnk.cts_n, 1'b0);
    rd(4'hC, ra);
    rd(HREG_STATUS, rb);
    chk(ra, rb); // status mirrored at an unmapped offset
    chk(rb, 32'h0000_0002);
    wr(HREG_CTRL, 32'h4);
    chk(lnk.ser_activity, 1'b0);
    chk(send_ok, 1'b0);
  endtask
  task automatic t_pin();
    wr(HREG_CFG, {16'd2, 16'h0001});
    busy <= 1'b1;
    wr(HREG_CTRL, 32'h1);
    chk(lnk.sleep_pin_function, 1'b1);
    repeat (20) @(posedge clk);
    chk(lnk.awake, 1'b1);
    busy <= 1'b0;
    wait_aw(1'b0, 20);
    chk(asleep, 1'b1);
    pulse(1'b0);
    repeat (10) @(posedge clk);
    chk(lnk.awake, 1'b0);
    wr(HREG_CTRL, 32'h0);
    wait_aw(1'b1, 10);
    repeat (6) @(posedge clk);
    chk(lnk.cts_n, 1'b0);
  endtask
  task automatic t_select();
    wr(HREG_CTRL, 32'h3);
    chk({lnk.sleep_pin_function, lnk.select_pin_function}, 2'b01);
    wait_aw(1'b0, 20);
    wr(HREG_CTRL, 32'h2);
    wait_aw(1'b1, 10);
    wr(HREG_CTRL, 32'h0);
  endtask
  task automatic t_cyclic();
    wr(HREG_STATUS, 32'd3);
    wr(HREG_CFG, {16'd2, 16'h0004});
    wait_aw(1'b0, 200);
    wait_poll();
    pulse(1'b1);
    wait_aw(1'b0, 10);
    wait_poll();
    pulse(1'b0);
    pulse(1'b1);
    stay_aw(TICK);
    wr(HREG_CFG, {16'd3, 16'h0104});
    wait_poll();
    pulse(1'b1);
    stay_aw(2 * TICK);
    wait_aw(1'b0, 60);
  endtask
  task automatic t_mode5();
    wr(HREG_STATUS, 32'd100);
    wr(HREG_CTRL, 32'h1);
    wr(HREG_CFG, {16'd3, 16'h0005});
    wait_poll();
    pulse(1'b1);
    wait_aw(1'b0, 300);
    wr(HREG_CTRL, 32'h0);
    wr(HREG_CTRL, 32'h1);
    wait_aw(1'b1, 10);
    stay_aw(2 * TICK);
    wait_aw(1'b0, 100);
  endtask
  // stimulus: reset for 20 cycles, then each scenario in turn
  initial begin
    rst = 1'b1; wr_s = 1'b0; rd_s = 1'b0; addr = '0; wdata = '0;
    busy = 1'b0; act = 1'b0; done = 1'b0; num_errors = 0; cmp_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_boot();
    t_pin();
    t_select();
    t_cyclic();
    t_mode5();
    summarize();
  end
  // watchdog sized well past the few hundred cycles the scenarios need
  initial begin
    #200us;
    num_errors++;
    summarize();
  end
endmodule // tb_radio_module_sleep_controller
